/* File: pkg/port_cfg_pkg.sv */
/*
  constants for the port 3 configuration and port 4 data registers.
  assumes an 8-bit special function register bus with a page select.
*/
package port_cfg_pkg;
  localparam logic [7:0] ADDR_P3_OUTPUT_DRIVE = 8'hae;
  localparam logic [7:0] ADDR_P4_DATA = 8'hb5;
  localparam logic [7:0] ADDR_P3_CROSSBAR_SKIP = 8'hd7;
  localparam logic [7:0] ADDR_P3_ANALOG_SELECT = 8'hf4;
  localparam logic [7:0] PAGE_CONFIG = 8'h0f;
  localparam logic [7:0] RST_P3_ANALOG_SELECT = 8'hff;
  localparam logic [7:0] RST_P3_OUTPUT_DRIVE = 8'h00;
  localparam logic [7:0] RST_P3_CROSSBAR_SKIP = 8'h00;
  localparam logic [7:0] RST_P4_DATA = 8'hff;
  localparam int SYNC_STAGES = 2;
endpackage

/* File: logic/pin_sync.sv */
/*
  two flip-flop synchroniser for a vector of pin levels.
  assumes pins are asynchronous to i_mclk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule // pin_sync

/* File: logic/port3_config_port4_data.sv */
/*
  port 3 pin configuration (analog select, output drive, crossbar skip)
  and the port 4 data register, on the special function register bus.
  assumes a single-cycle register bus with page select from the core;
  pins are joined outside from the output/enable signals given here.
  assumes the bus strobes come from logic on i_mclk, so they are used
  directly; port 4 pad levels are asynchronous and pass two flops first.
  pad controls are registered and change in the cycle after a write.
  read data holds until the next read; the hit flag is a one-cycle pulse.
*/
`timescale 1ns/1ps
module port3_config_port4_data
  import port_cfg_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic [WIDTH-1:0] o_p3_analog_mode,
  output logic [WIDTH-1:0] o_p3_pullup_en,
  output logic [WIDTH-1:0] o_p3_rx_en,
  output logic [WIDTH-1:0] o_p3_push_pull,
  output logic [WIDTH-1:0] o_p3_crossbar_skip,
  input wire logic [WIDTH-1:0] i_p4_pin,
  output logic [WIDTH-1:0] o_p4_pin,
  output logic [WIDTH-1:0] o_p4_pin_oe_n
);
  // register state and its next values
  logic [WIDTH-1:0] analog_sel_r;
  logic [WIDTH-1:0] analog_sel_nxt;
  logic [WIDTH-1:0] out_drive_r;
  logic [WIDTH-1:0] out_drive_nxt;
  logic [WIDTH-1:0] skip_r;
  logic [WIDTH-1:0] skip_nxt;
  logic [WIDTH-1:0] p4_latch_r;
  logic [WIDTH-1:0] p4_latch_nxt;

  // registered pad controls
  logic [WIDTH-1:0] analog_mode_r;
  logic [WIDTH-1:0] analog_mode_nxt;
  logic [WIDTH-1:0] pullup_en_r;
  logic [WIDTH-1:0] pullup_en_nxt;
  logic [WIDTH-1:0] rx_en_r;
  logic [WIDTH-1:0] rx_en_nxt;
  logic [WIDTH-1:0] push_pull_r;
  logic [WIDTH-1:0] push_pull_nxt;

  // read response
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic hit_r;
  logic hit_nxt;

  // bus decode
  logic [WIDTH-1:0] p4_pin_sync;
  logic sel_analog;
  logic sel_drive;
  logic sel_skip;
  logic sel_p4;
  logic wr_analog;
  logic wr_drive;
  logic wr_skip;
  logic wr_p4;
  logic rd_mapped;

  // widen a pin vector to the bus width
  function automatic logic [7:0] widen(input logic [WIDTH-1:0] v);
    logic [7:0] r;
    r = '0;
    r[WIDTH-1:0] = v;
    return r;
  endfunction

  // address match, with or without the configuration page
  function automatic logic reg_hit(
    input logic [7:0] addr,
    input logic [7:0] page,
    input logic [7:0] reg_addr,
    input logic paged
  );
    logic page_ok;
    page_ok = !paged || (page == PAGE_CONFIG);
    return page_ok && (addr == reg_addr);
  endfunction

  // read data for a decoded register, zero when nothing matches
  function automatic logic [7:0] read_mux(
    input logic s_analog,
    input logic s_drive,
    input logic s_skip,
    input logic s_p4,
    input logic [WIDTH-1:0] v_analog,
    input logic [WIDTH-1:0] v_drive,
    input logic [WIDTH-1:0] v_skip,
    input logic [WIDTH-1:0] v_pins
  );
    logic [7:0] r;
    r = 8'h00;
    if (s_analog) begin
      r = widen(v_analog);
    end else if (s_drive) begin
      r = widen(v_drive);
    end else if (s_skip) begin
      r = widen(v_skip);
    end else if (s_p4) begin
      r = widen(v_pins);
    end
    return r;
  endfunction

  // pad levels are asynchronous: two flops before any use
  pin_sync #(
    .WIDTH(WIDTH)
  ) u_p4_sync (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_async(i_p4_pin),
    .o_sync(p4_pin_sync)
  );

  // config registers answer on page 15 only, port 4 data on every page
  assign sel_analog = reg_hit(i_sfr_addr, i_sfr_page, ADDR_P3_ANALOG_SELECT, 1'b1);
  assign sel_drive = reg_hit(i_sfr_addr, i_sfr_page, ADDR_P3_OUTPUT_DRIVE, 1'b1);
  assign sel_skip = reg_hit(i_sfr_addr, i_sfr_page, ADDR_P3_CROSSBAR_SKIP, 1'b1);
  assign sel_p4 = reg_hit(i_sfr_addr, i_sfr_page, ADDR_P4_DATA, 1'b0);

  // write strobes per register
  assign wr_analog = i_sfr_wr && sel_analog;
  assign wr_drive = i_sfr_wr && sel_drive;
  assign wr_skip = i_sfr_wr && sel_skip;
  assign wr_p4 = i_sfr_wr && sel_p4;
  assign rd_mapped = i_sfr_rd && (sel_analog || sel_drive || sel_skip || sel_p4);

  // analog-select register
  always_comb begin
    analog_sel_nxt = analog_sel_r;
    if (wr_analog) begin
      analog_sel_nxt = i_sfr_wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      analog_sel_r <= RST_P3_ANALOG_SELECT[WIDTH-1:0];
    end else begin
      analog_sel_r <= analog_sel_nxt;
    end
  end

  // output-drive register
  always_comb begin
    out_drive_nxt = out_drive_r;
    if (wr_drive) begin
      out_drive_nxt = i_sfr_wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      out_drive_r <= RST_P3_OUTPUT_DRIVE[WIDTH-1:0];
    end else begin
      out_drive_r <= out_drive_nxt;
    end
  end

  // crossbar-skip register
  always_comb begin
    skip_nxt = skip_r;
    if (wr_skip) begin
      skip_nxt = i_sfr_wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      skip_r <= RST_P3_CROSSBAR_SKIP[WIDTH-1:0];
    end else begin
      skip_r <= skip_nxt;
    end
  end

  // port 4 output latches
  always_comb begin
    p4_latch_nxt = p4_latch_r;
    if (wr_p4) begin
      p4_latch_nxt = i_sfr_wdata[WIDTH-1:0];
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      p4_latch_r <= RST_P4_DATA[WIDTH-1:0];
    end else begin
      p4_latch_r <= p4_latch_nxt;
    end
  end

  // analog pads: taken from the next values so they move with the register
  always_comb begin
    analog_mode_nxt = ~analog_sel_nxt;
    pullup_en_nxt = analog_sel_nxt;
    rx_en_nxt = analog_sel_nxt;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      analog_mode_r <= ~RST_P3_ANALOG_SELECT[WIDTH-1:0];
      pullup_en_r <= RST_P3_ANALOG_SELECT[WIDTH-1:0];
      rx_en_r <= RST_P3_ANALOG_SELECT[WIDTH-1:0];
    end else begin
      analog_mode_r <= analog_mode_nxt;
      pullup_en_r <= pullup_en_nxt;
      rx_en_r <= rx_en_nxt;
    end
  end

  // push-pull only on digital pins; drive bit ignored on analog pins
  always_comb begin
    push_pull_nxt = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (analog_sel_nxt[i]) begin
        push_pull_nxt[i] = out_drive_nxt[i];
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      push_pull_r <= RST_P3_OUTPUT_DRIVE[WIDTH-1:0] & RST_P3_ANALOG_SELECT[WIDTH-1:0];
    end else begin
      push_pull_r <= push_pull_nxt;
    end
  end

  // read data: holds until the next read
  always_comb begin
    rdata_nxt = rdata_r;
    if (i_sfr_rd) begin
      rdata_nxt = read_mux(
        sel_analog,
        sel_drive,
        sel_skip,
        sel_p4,
        analog_sel_r,
        out_drive_r,
        skip_r,
        p4_pin_sync
      );
    end
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // hit: one-cycle pulse after a read of a mapped register
  always_comb begin
    hit_nxt = rd_mapped;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hit_r <= 1'b0;
    end else begin
      hit_r <= hit_nxt;
    end
  end

  // outputs straight from flip-flops
  assign o_sfr_rdata = rdata_r;
  assign o_sfr_hit = hit_r;
  assign o_p3_analog_mode = analog_mode_r;
  assign o_p3_pullup_en = pullup_en_r;
  assign o_p3_rx_en = rx_en_r;
  assign o_p3_push_pull = push_pull_r;
  assign o_p3_crossbar_skip = skip_r;
  assign o_p4_pin = p4_latch_r;
  // port 4 drives low on latch 0; high level left to the pad (open-drain)
  assign o_p4_pin_oe_n = p4_latch_r;
endmodule // port3_config_port4_data

/* File: testbench/port_cfg_properties.sv */
/* port block checker; bound by the bench */
`timescale 1ns/1ps
module port_cfg_properties (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_page,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic o_sfr_hit,
  input wire logic [7:0] o_p3_analog_mode,
  input wire logic [7:0] o_p3_pullup_en,
  input wire logic [7:0] o_p3_push_pull,
  input wire logic [7:0] o_p3_crossbar_skip,
  input wire logic [7:0] o_p4_pin
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  wire cfg_wr = i_sfr_wr && i_sfr_page == 8'h0f;
  property p_an; cfg_wr && i_sfr_addr == 8'hf4 |=> o_p3_analog_mode == ~$past(i_sfr_wdata); endproperty
  a_an: assert property (p_an) else $error("am");
  property p_pu; o_p3_pullup_en == ~o_p3_analog_mode; endproperty
  a_pu: assert property (p_pu) else $error("pu");
  property p_pp; (o_p3_push_pull & o_p3_analog_mode) == 8'h00; endproperty
  a_pp: assert property (p_pp) else $error("pp");
  property p_dr; cfg_wr && i_sfr_addr == 8'hae |=> o_p3_push_pull == ($past(i_sfr_wdata) & ~o_p3_analog_mode); endproperty
  a_dr: assert property (p_dr) else $error("dr");
  property p_sk; cfg_wr && i_sfr_addr == 8'hd7 |=> o_p3_crossbar_skip == $past(i_sfr_wdata); endproperty
  a_sk: assert property (p_sk) else $error("sk");
  property p_wr; i_sfr_wr && i_sfr_addr == 8'hb5 |=> o_p4_pin == $past(i_sfr_wdata); endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_hit; i_sfr_rd && i_sfr_addr == 8'hb5 |=> o_sfr_hit; endproperty
  a_hit: assert property (p_hit) else $error("hit");
  property p_pg; i_sfr_wr && i_sfr_page != 8'h0f |=> $stable(o_p3_crossbar_skip); endproperty
  a_pg: assert property (p_pg) else $error("pg");
  cover property (cfg_wr);
  cover property (i_sfr_rd ##1 o_sfr_hit);
  cover property (i_sfr_wr && i_sfr_addr == 8'hb5);
endmodule // port_cfg_properties

/* File: testbench/p4_pad_model.sv */
/* port 4 pads: pull-up when released; bench may hold pins low */
`timescale 1ns/1ps
module p4_pad_model (
  input wire logic [7:0] i_latch,
  input wire logic [7:0] i_oe_n,
  input wire logic [7:0] i_low_mask,
  output logic [7:0] o_pad
);
  assign o_pad = (i_latch | i_oe_n) & ~i_low_mask;
endmodule // p4_pad_model

/* File: testbench/port3_config_port4_data_bench.sv */
/* bench: register accesses with expected values; pads modelled apart */
`timescale 1ns/1ps
module port3_config_port4_data_bench;
  logic i_mclk = 0, i_sys_rst = 1, i_sfr_wr = 0, i_sfr_rd = 0, o_sfr_hit;
  logic [7:0] i_sfr_addr = 0, i_sfr_page = 0, i_sfr_wdata = 0, low = 0, i_p4_pin, o_sfr_rdata;
  logic [7:0] o_p3_analog_mode, o_p3_pullup_en, o_p3_rx_en, o_p3_push_pull;
  logic [7:0] o_p3_crossbar_skip, o_p4_pin, o_p4_pin_oe_n;
  int n_fail = 0, tests_run = 0, cyc = 0;
  port3_config_port4_data dut (.*);
  p4_pad_model pads (.i_latch(o_p4_pin), .i_oe_n(o_p4_pin_oe_n), .i_low_mask(low), .o_pad(i_p4_pin));
  initial forever #4 i_mclk = ~i_mclk;
  always @(posedge i_mclk) if (++cyc > 2000) begin
    n_fail++;
    stop_test;
  end
  task automatic chk(string n, logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] p, logic [7:0] d);
    @(negedge i_mclk);
    {i_sfr_wr, i_sfr_rd, i_sfr_addr, i_sfr_page, i_sfr_wdata} = {w, ~w, a, p, d};
    @(negedge i_mclk);
    {i_sfr_wr, i_sfr_rd} = 2'h0;
  endtask
  task automatic stop_test;
    if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge i_mclk);
    i_sys_rst = 0;
    chk("am", o_p3_analog_mode, 8'h00);
    chk("pu", o_p3_pullup_en, 8'hff);
    chk("pp", o_p3_push_pull, 8'h00);
    chk("sk", o_p3_crossbar_skip, 8'h00);
    chk("p4", o_p4_pin, 8'hff);
    chk("oe", o_p4_pin_oe_n, 8'hff);
    acc(1, 8'hae, 8'h0f, 8'hff);
    chk("pp", o_p3_push_pull, 8'hff);
    acc(1, 8'hae, 8'h0f, 8'h5a);
    acc(1, 8'hf4, 8'h0f, 8'h5a);
    chk("am", o_p3_analog_mode, 8'ha5);
    chk("rx", o_p3_rx_en, 8'h5a);
    chk("pu", o_p3_pullup_en, 8'h5a);
    chk("pp", o_p3_push_pull, 8'h5a);
    acc(1, 8'hd7, 8'h0e, 8'h3c);
    chk("sk", o_p3_crossbar_skip, 8'h00);
    acc(1, 8'hd7, 8'h0f, 8'hff);
    chk("sk", o_p3_crossbar_skip, 8'hff);
    acc(1, 8'hf4, 8'h0e, 8'h00);
    chk("am", o_p3_analog_mode, 8'ha5);
    acc(0, 8'hf4, 8'h0f, 8'h00);
    chk("rd", o_sfr_rdata, 8'h5a);
    acc(0, 8'hae, 8'h0f, 8'h00);
    chk("rd", o_sfr_rdata, 8'h5a);
    acc(0, 8'hd7, 8'h0f, 8'h00);
    chk("rd", o_sfr_rdata, 8'hff);
    acc(0, 8'hd7, 8'h0e, 8'h00);
    chk("rd", o_sfr_rdata, 8'h00);
    chk("hit", {7'h0, o_sfr_hit}, 8'h00);
    acc(1, 8'hb5, 8'h03, 8'h96);
    chk("p4", o_p4_pin, 8'h96);
    chk("oe", o_p4_pin_oe_n, 8'h96);
    low = 8'h11;
    repeat (3) @(negedge i_mclk);
    acc(0, 8'hb5, 8'h07, 8'h00);
    chk("rd", o_sfr_rdata, 8'h86);
    chk("hit", {7'h0, o_sfr_hit}, 8'h01);
    acc(0, 8'h12, 8'h0f, 8'h00);
    chk("rd", o_sfr_rdata, 8'h00);
    stop_test;
  end
endmodule // port3_config_port4_data_bench
bind port3_config_port4_data port_cfg_properties chk_u (.*);
